/* File: design/lsc_pkg.sv */
// Constants, register map and types of the line status and clock configuration block.
// Function
// - The D-channel clock output is the 16 kHz D-channel clock when its select bit is 0 and a free 8 kHz 50% clock when it is 1.
// - Bit 2 of the configuration register sets the phase of the second B-channel bit clock against the internal sample clock.
// - Bit 3 of the configuration register sets the phase of the first B-channel bit clock against the internal sample clock.
// - With the live-read bit set reads follow changing status while the read is pending, otherwise they return the value caught at the start.
// - The previous-pattern field holds the received pattern that raised the last line-change interrupt, in the current-pattern encoding.
// - The previous-pattern field stays frozen after the interrupt while the current-pattern field keeps updating.
// - The current-pattern field reports 00 for Info 0, 01 for Info 2, 10 for Info 4 and 11 for lost framing.
// - A run of 64 consecutive binary ones on the line is classified as Info 0.
// - A framed signal with A bit 0 and all B and D bits zero is Info 2, and one with A bit 1 is Info 4.
// - Framing is declared lost when two 48-bit frames pass without a valid pair of code violations.
package lsc_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [3:0] IDX_HW_CONFIG   = 4'h0;
	localparam logic [3:0] IDX_LINE_STATE  = 4'h1;
	localparam logic [3:0] IDX_IRQ_MASK    = 4'h9;
	localparam logic [3:0] IDX_IRQ_STATUS  = 4'hA;
	localparam int         ADDR_LSB        = 2;
	localparam int         IDX_W           = 4;

	// Configuration register fields
	localparam int         CFG_DCLK_SEL    = 1;
	localparam int         CFG_B2_PHASE    = 2;
	localparam int         CFG_B1_PHASE    = 3;
	localparam int         CFG_LIVE_READ   = 4;
	localparam logic [7:0] CFG_WR_MASK     = 8'h1E;
	localparam logic [7:0] CFG_RESET       = 8'h00;

	// Line state fields and the line-change interrupt bit
	localparam int         LS_PREV_LSB     = 0;
	localparam int         LS_CUR_LSB      = 2;
	localparam int         IRQ_LINE_CHG    = 1;
	localparam logic [7:0] IRQ_IMPL_MASK   = 8'h02;
	localparam logic [7:0] IRQ_RESET       = 8'h00;

	// AXI responses
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	// Line classification
	localparam int         ONES_RUN        = 64;
	localparam int         FRAME_BITS      = 48;
	localparam int         LOST_BITS       = 2 * FRAME_BITS;

	// Clock rates
	localparam int         SYS_CLK_HZ      = 200_000_000;
	localparam int         DCLK_HZ         = 16_000;
	localparam int         FREE_CLK_HZ     = 8_000;
	localparam int         BCLK_HZ         = 64_000;
	localparam int         DCLK_HALF       = SYS_CLK_HZ / (2 * DCLK_HZ);
	localparam int         FREE_HALF       = SYS_CLK_HZ / (2 * FREE_CLK_HZ);
	localparam int         BCLK_HALF       = SYS_CLK_HZ / (2 * BCLK_HZ);

	// Received information pattern, coded as in the status field
	typedef enum logic [1:0] {
		PAT_INFO0 = 2'h0,
		PAT_INFO2 = 2'h1,
		PAT_INFO4 = 2'h2,
		PAT_LOST  = 2'h3
	} lsc_pat_t;
endpackage : lsc_pkg

/* File: design/lsc_top.sv */
// Line status, clock configuration and line-change interrupt with an AXI4-Lite slave.
`timescale 1ns/100ps
module lsc_top #(
	parameter int DCLK_HALF = lsc_pkg::DCLK_HALF,
	parameter int FREE_HALF = lsc_pkg::FREE_HALF,
	parameter int BCLK_HALF = lsc_pkg::BCLK_HALF
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// AXI4-Lite write channels
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// AXI4-Lite read channels
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Received line, one strobe per line bit
	input  wire logic        line_bit_stb_i,
	input  wire logic        line_bit_i,
	input  wire logic        line_cv_pair_i,
	input  wire logic        line_a_bit_i,
	input  wire logic        line_bd_zero_i,
	// Clock outputs and interrupt
	output logic             dchan_clk_o,
	output logic             first_bchan_bit_clk_o,
	output logic             second_bchan_bit_clk_o,
	output logic             irq_o
);
	localparam int DW = $clog2(FREE_HALF + 1);
	localparam int BW = $clog2(BCLK_HALF + 1);
	localparam int OW = $clog2(lsc_pkg::ONES_RUN + 1);
	localparam int LW = $clog2(lsc_pkg::LOST_BITS + 1);

	logic [7:0]                  cfg_q;
	logic [7:0]                  mask_q;
	logic [7:0]                  stat_q;
	lsc_pkg::lsc_pat_t           pat_q;
	lsc_pkg::lsc_pat_t           pat_d;
	lsc_pkg::lsc_pat_t           prev_q;
	logic [OW-1:0]               ones_q;
	logic [LW-1:0]               nocv_q;
	logic [DW-1:0]               dcnt_q;
	logic [BW-1:0]               bcnt_q;
	logic                        dclk_q;
	logic                        free_q;
	logic                        bclk_q;
	logic                        aw_have_q;
	logic                        w_have_q;
	logic [lsc_pkg::IDX_W-1:0]   aw_idx_q;
	logic [lsc_pkg::IDX_W-1:0]   ar_idx_q;
	logic [31:0]                 wdata_q;
	logic                        wstrb0_q;
	logic                        wr_go;
	logic                        line_chg;
	logic [7:0]                  line_state;
	logic [31:0]                 rd_mux;
	logic                        rd_ok;
	logic                        rd_pend_q;

	assign line_state = {4'h0, pat_q, prev_q};
	assign line_chg   = (pat_d != pat_q);

	// Line classification
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ones_q <= '0;
		end else if (line_bit_stb_i) begin
			if (!line_bit_i)
				ones_q <= '0;
			else if (ones_q != OW'(lsc_pkg::ONES_RUN))
				ones_q <= ones_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			nocv_q <= '0;
		end else if (line_cv_pair_i) begin
			nocv_q <= '0;
		end else if (line_bit_stb_i && nocv_q != LW'(lsc_pkg::LOST_BITS)) begin
			nocv_q <= nocv_q + 1'b1;
		end
	end

	always_comb begin
		pat_d = pat_q;
		if (ones_q == OW'(lsc_pkg::ONES_RUN))
			pat_d = lsc_pkg::PAT_INFO0;
		else if (nocv_q == LW'(lsc_pkg::LOST_BITS) && !line_cv_pair_i)
			pat_d = lsc_pkg::PAT_LOST;
		else if (line_cv_pair_i && line_a_bit_i)
			pat_d = lsc_pkg::PAT_INFO4;
		else if (line_cv_pair_i && line_bd_zero_i)
			pat_d = lsc_pkg::PAT_INFO2;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			pat_q <= lsc_pkg::PAT_INFO0;
		else
			pat_q <= pat_d;
	end

	// Previous pattern frozen while the change interrupt is pending
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			prev_q <= lsc_pkg::PAT_INFO0;
		else if (line_chg && !stat_q[lsc_pkg::IRQ_LINE_CHG])
			prev_q <= pat_d;
	end

	// Clock generation
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dcnt_q <= '0;
			free_q <= 1'b0;
			dclk_q <= 1'b0;
		end else if (dcnt_q == DW'(FREE_HALF - 1)) begin
			dcnt_q <= '0;
			free_q <= ~free_q;
			dclk_q <= ~dclk_q;
		end else begin
			dcnt_q <= dcnt_q + 1'b1;
			if (dcnt_q == DW'(DCLK_HALF - 1))
				dclk_q <= ~dclk_q;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bcnt_q <= '0;
			bclk_q <= 1'b0;
		end else if (bcnt_q == BW'(BCLK_HALF - 1)) begin
			bcnt_q <= '0;
			bclk_q <= ~bclk_q;
		end else begin
			bcnt_q <= bcnt_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dchan_clk_o            <= 1'b0;
			first_bchan_bit_clk_o  <= 1'b0;
			second_bchan_bit_clk_o <= 1'b0;
		end else begin
			dchan_clk_o            <= cfg_q[lsc_pkg::CFG_DCLK_SEL] ? free_q : dclk_q;
			first_bchan_bit_clk_o  <= bclk_q ^ cfg_q[lsc_pkg::CFG_B1_PHASE];
			second_bchan_bit_clk_o <= bclk_q ^ cfg_q[lsc_pkg::CFG_B2_PHASE];
		end
	end

	// AXI write path
	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid_o;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_have_q       <= 1'b0;
			w_have_q        <= 1'b0;
			aw_idx_q        <= '0;
			wdata_q         <= '0;
			wstrb0_q        <= 1'b0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= lsc_pkg::RESP_OKAY;
		end else begin
			s_axi_awready_o <= !aw_have_q && !(s_axi_awvalid_i && s_axi_awready_o);
			s_axi_wready_o  <= !w_have_q && !(s_axi_wvalid_i && s_axi_wready_o);
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_q <= 1'b1;
				aw_idx_q  <= s_axi_awaddr_i[lsc_pkg::ADDR_LSB +: lsc_pkg::IDX_W];
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata_i;
				wstrb0_q <= s_axi_wstrb_i[0];
			end
			if (wr_go) begin
				aw_have_q      <= 1'b0;
				w_have_q       <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (aw_idx_q == lsc_pkg::IDX_HW_CONFIG ||
				                   aw_idx_q == lsc_pkg::IDX_IRQ_MASK ||
				                   aw_idx_q == lsc_pkg::IDX_IRQ_STATUS) ?
				                  lsc_pkg::RESP_OKAY : lsc_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// Reserved configuration bits are not stored and read as zero
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			cfg_q <= lsc_pkg::CFG_RESET;
		else if (wr_go && wstrb0_q && aw_idx_q == lsc_pkg::IDX_HW_CONFIG)
			cfg_q <= wdata_q[7:0] & lsc_pkg::CFG_WR_MASK;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			mask_q <= lsc_pkg::IRQ_RESET;
		else if (wr_go && wstrb0_q && aw_idx_q == lsc_pkg::IDX_IRQ_MASK)
			mask_q <= wdata_q[7:0] & lsc_pkg::IRQ_IMPL_MASK;
	end

	// Sticky status, write one to clear, a new change wins over the clear
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stat_q <= lsc_pkg::IRQ_RESET;
		end else begin
			if (wr_go && wstrb0_q && aw_idx_q == lsc_pkg::IDX_IRQ_STATUS)
				stat_q <= stat_q & ~wdata_q[7:0];
			if (line_chg)
				stat_q[lsc_pkg::IRQ_LINE_CHG] <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(stat_q & mask_q);
	end

	// AXI read path
	always_comb begin
		rd_mux = '0;
		rd_ok  = 1'b1;
		case (ar_idx_q)
			lsc_pkg::IDX_HW_CONFIG:  rd_mux[7:0] = cfg_q;
			lsc_pkg::IDX_LINE_STATE: rd_mux[7:0] = line_state;
			lsc_pkg::IDX_IRQ_MASK:   rd_mux[7:0] = mask_q;
			lsc_pkg::IDX_IRQ_STATUS: rd_mux[7:0] = stat_q;
			default:                 rd_ok       = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ar_idx_q        <= '0;
			s_axi_arready_o <= 1'b0;
		end else begin
			s_axi_arready_o <= !s_axi_rvalid_o && !rd_pend_q &&
			                   !(s_axi_arvalid_i && s_axi_arready_o);
			if (s_axi_arvalid_i && s_axi_arready_o)
				ar_idx_q <= s_axi_araddr_i[lsc_pkg::ADDR_LSB +: lsc_pkg::IDX_W];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= '0;
			s_axi_rresp_o  <= lsc_pkg::RESP_OKAY;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end else if (!s_axi_rvalid_o && rd_pend_q) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= rd_mux;
			s_axi_rresp_o  <= rd_ok ? lsc_pkg::RESP_OKAY : lsc_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid_o && cfg_q[lsc_pkg::CFG_LIVE_READ]) begin
			s_axi_rdata_o  <= rd_mux;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			rd_pend_q <= 1'b0;
		else if (s_axi_arvalid_i && s_axi_arready_o)
			rd_pend_q <= 1'b1;
		else if (rd_pend_q && !s_axi_rvalid_o)
			rd_pend_q <= 1'b0;
	end

	// Checks
	a_info0_run: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ones_q == OW'(lsc_pkg::ONES_RUN)) |=> (pat_q == lsc_pkg::PAT_INFO0))
		else $error("Run of ones not reported as Info 0");
	a_lost_frame: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(nocv_q == LW'(lsc_pkg::LOST_BITS) && ones_q != OW'(lsc_pkg::ONES_RUN)
		 && !line_cv_pair_i) |=> (pat_q == lsc_pkg::PAT_LOST))
		else $error("Missing code violations not reported as lost framing");
	a_info4_seen: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(line_cv_pair_i && line_a_bit_i && ones_q != OW'(lsc_pkg::ONES_RUN))
		|=> (pat_q == lsc_pkg::PAT_INFO4))
		else $error("Framed A=1 signal not reported as Info 4");
	a_info2_seen: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(line_cv_pair_i && !line_a_bit_i && line_bd_zero_i
		 && ones_q != OW'(lsc_pkg::ONES_RUN)) |=> (pat_q == lsc_pkg::PAT_INFO2))
		else $error("Framed idle signal not reported as Info 2");
	a_cur_field: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		($rose(s_axi_rvalid_o) && $past(ar_idx_q) == lsc_pkg::IDX_LINE_STATE)
		|-> (s_axi_rdata_o[lsc_pkg::LS_CUR_LSB +: 2] == $past(pat_q)))
		else $error("Current pattern field does not follow the receiver");
	a_pat_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$changed(pat_q) |-> ($past(ones_q) == OW'(lsc_pkg::ONES_RUN) ||
		 $past(nocv_q) == LW'(lsc_pkg::LOST_BITS) || $past(line_cv_pair_i)))
		else $error("Current pattern moved with no line event");
	a_prev_capture: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		($changed(pat_q) && !$past(stat_q[lsc_pkg::IRQ_LINE_CHG]))
		|-> (prev_q == pat_q && stat_q[lsc_pkg::IRQ_LINE_CHG]))
		else $error("Previous pattern not caught with the change interrupt");
	a_prev_frozen: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		stat_q[lsc_pkg::IRQ_LINE_CHG] |=> (stat_q[lsc_pkg::IRQ_LINE_CHG]
		|| $stable(prev_q)) and (!stat_q[lsc_pkg::IRQ_LINE_CHG] || $stable(prev_q)))
		else $error("Previous pattern moved while the interrupt is pending");
	a_dclk_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(cfg_q[lsc_pkg::CFG_DCLK_SEL] ##1 cfg_q[lsc_pkg::CFG_DCLK_SEL])
		|-> (dchan_clk_o == $past(free_q)))
		else $error("D-channel clock output ignores its select bit");
	a_b1_phase: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		##1 first_bchan_bit_clk_o == ($past(bclk_q) ^ $past(cfg_q[lsc_pkg::CFG_B1_PHASE])))
		else $error("First B-channel clock phase wrong");
	a_b2_phase: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		##1 second_bchan_bit_clk_o == ($past(bclk_q) ^ $past(cfg_q[lsc_pkg::CFG_B2_PHASE])))
		else $error("Second B-channel clock phase wrong");
	a_latched_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(s_axi_rvalid_o && !s_axi_rready_i && !cfg_q[lsc_pkg::CFG_LIVE_READ])
		|=> $stable(s_axi_rdata_o))
		else $error("Latched read data changed while pending");
	a_chg_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		line_chg |=> stat_q[lsc_pkg::IRQ_LINE_CHG])
		else $error("Line change lost against a status clear");
	a_irq_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		irq_o == $past(|(stat_q & mask_q)))
		else $error("Interrupt output does not follow status and mask");
	a_wr_resp: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_go |=> s_axi_bvalid_o)
		else $error("Write response missing after both channels taken");
	a_rd_resp: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(s_axi_arvalid_i && s_axi_arready_o) |-> ##2 s_axi_rvalid_o)
		else $error("Read response missing two cycles after the address");
endmodule : lsc_top

/* File: test/lsc_nt_model.sv */
// Network termination stand-in that sends line bits and framed patterns.
`timescale 1ns/100ps
module lsc_nt_model (
	// Clock
	input  wire logic clk_i,
	// Received line
	output logic      stb_o,
	output logic      bit_o,
	output logic      cv_o,
	output logic      a_o,
	output logic      bdz_o
);
	logic act;

	initial begin
		{act, stb_o, bit_o, cv_o, a_o, bdz_o} = 6'h00;
	end

	// Idle bit, A and B/D lines wander so a stale level is never mistaken for data
	always @(posedge clk_i) begin
		if (!act) begin
			bit_o <= ~bit_o;
			a_o   <= ~a_o;
			bdz_o <= ~bdz_o;
		end
	end

	// Line bits, one strobe every other cycle
	task bits(input int n, input logic v);
		act = 1'b1;
		repeat (n) begin
			@(posedge clk_i);
			stb_o <= 1'b1;
			bit_o <= v;
			@(posedge clk_i);
			stb_o <= 1'b0;
			bit_o <= ~v;
		end
		@(posedge clk_i);
		act = 1'b0;
	endtask : bits

	// One frame sync with its A bit and B/D content
	task frame(input logic a, input logic bdz);
		act = 1'b1;
		@(posedge clk_i);
		cv_o  <= 1'b1;
		a_o   <= a;
		bdz_o <= bdz;
		@(posedge clk_i);
		cv_o  <= 1'b0;
		a_o   <= ~a;
		bdz_o <= ~bdz;
		@(posedge clk_i);
		act = 1'b0;
	endtask : frame
endmodule : lsc_nt_model

/* File: test/test_line_status_and_clock_config.sv */
// Self-checking bench for the line status and clock configuration block.
`timescale 1ns/100ps
module test_line_status_and_clock_config;
	localparam int DH = 4;
	localparam int FH = 8;
	logic        clk, rst, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
	logic [7:0]  awa, ara, cfg;
	logic [31:0] wd, rdt;
	logic [1:0]  bresp, rresp, cur_e, prev_e;
	logic        stb, lbit, cv, abit, bdz, dclk, b1clk, b2clk, irq, st_e, msk_e;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          hi, lo, k;

	lsc_top #(.DCLK_HALF(DH), .FREE_HALF(FH), .BCLK_HALF(2)) u_dut (
		.sys_clk_i(clk), .rst_i(rst),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdt), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
		.line_bit_stb_i(stb), .line_bit_i(lbit), .line_cv_pair_i(cv), .line_a_bit_i(abit),
		.line_bd_zero_i(bdz),
		.dchan_clk_o(dclk), .first_bchan_bit_clk_o(b1clk), .second_bchan_bit_clk_o(b2clk),
		.irq_o(irq)
	);

	lsc_nt_model u_nt (.clk_i(clk), .stb_o(stb), .bit_o(lbit), .cv_o(cv), .a_o(abit), .bdz_o(bdz));

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awa <= {2'h0, idx, 2'h0};
		wd  <= {24'h000000, d};
		awv <= 1'b1;
		wv  <= 1'b1;
		br  <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
			n++;
		end while (!bv && n < 100);
		br <= 1'b0;
		chk("bvalid", 32'h1, {31'h0, bv});
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr

	task rd(input logic [3:0] idx, input logic [7:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		ara <= {2'h0, idx, 2'h0};
		arv <= 1'b1;
		rr  <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
			n++;
		end while (!rv && n < 100);
		rr <= 1'b0;
		chk("rvalid", 32'h1, {31'h0, rv});
		chk("rdata", {24'h000000, e}, rdt);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : rd

	// Cycles high and low of one whole D clock period
	task meas;
		int n;
		n = 0;
		hi = 0;
		lo = 0;
		while (dclk && n < 9999) begin
			@(posedge clk);
			n++;
		end
		while (!dclk && n < 9999) begin
			@(posedge clk);
			n++;
		end
		while (dclk && n < 9999) begin
			@(posedge clk);
			hi++;
			n++;
		end
		while (!dclk && n < 9999) begin
			@(posedge clk);
			lo++;
			n++;
		end
	endtask : meas

	task msk(input logic m);
		msk_e = m;
		wr(lsc_pkg::IDX_IRQ_MASK, {6'h00, m, 1'b0}, lsc_pkg::RESP_OKAY);
		rd(lsc_pkg::IDX_IRQ_MASK, {6'h00, m, 1'b0}, lsc_pkg::RESP_OKAY);
	endtask : msk

	task clr;
		st_e = 1'b0;
		wr(lsc_pkg::IDX_IRQ_STATUS, 8'h02, lsc_pkg::RESP_OKAY);
	endtask : clr

	// Status, previous and current pattern after the line settles on p
	task expect_pat(input logic [1:0] p);
		if (p != cur_e) begin
			if (!st_e) prev_e = p;
			st_e = 1'b1;
		end
		cur_e = p;
		rd(lsc_pkg::IDX_LINE_STATE, {4'h0, cur_e, prev_e}, lsc_pkg::RESP_OKAY);
		rd(lsc_pkg::IDX_IRQ_STATUS, {6'h00, st_e, 1'b0}, lsc_pkg::RESP_OKAY);
		chk("irq", {31'h0, st_e & msk_e}, {31'h0, irq});
	endtask : expect_pat

	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#200000;
		n_fail++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		{awv, wv, br, arv, rr} = 5'h00;
		{awa, ara, wd} = '0;
		{cur_e, prev_e, st_e, msk_e} = 6'h00;
		void'($urandom(50));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(lsc_pkg::IDX_HW_CONFIG, 8'h00, lsc_pkg::RESP_OKAY);
		rd(lsc_pkg::IDX_LINE_STATE, 8'h00, lsc_pkg::RESP_OKAY);
		rd(lsc_pkg::IDX_IRQ_STATUS, 8'h00, lsc_pkg::RESP_OKAY);
		rd(4'h5, 8'h00, lsc_pkg::RESP_SLVERR);
		wr(4'h5, 8'h1E, lsc_pkg::RESP_SLVERR);
		$display("reset and map test done");
		for (int i = 0; i < 8; i++) begin
			cfg = 8'($urandom) & 8'h1E;
			wr(lsc_pkg::IDX_HW_CONFIG, cfg, lsc_pkg::RESP_OKAY);
			rd(lsc_pkg::IDX_HW_CONFIG, cfg, lsc_pkg::RESP_OKAY);
			repeat (4) begin
				@(posedge clk);
				chk("bclk phase", {31'h0, cfg[3] ^ cfg[2]}, {31'h0, b1clk ^ b2clk});
			end
		end
		$display("config test done");
		wr(lsc_pkg::IDX_HW_CONFIG, 8'h00, lsc_pkg::RESP_OKAY);
		meas();
		meas();
		chk("dclk period", 2 * DH, hi + lo);
		wr(lsc_pkg::IDX_HW_CONFIG, 8'h02, lsc_pkg::RESP_OKAY);
		meas();
		meas();
		chk("free clk high", FH, hi);
		chk("free clk low", FH, lo);
		$display("clock test done");
		msk(1'b1);
		u_nt.bits(95, 1'b0);
		expect_pat(lsc_pkg::PAT_INFO0);
		u_nt.bits(1, 1'b0);
		expect_pat(lsc_pkg::PAT_LOST);
		u_nt.frame(1'b0, 1'b1);
		expect_pat(lsc_pkg::PAT_INFO2);
		u_nt.frame(1'b0, 1'b0);
		expect_pat(lsc_pkg::PAT_INFO2);
		clr();
		msk(1'b0);
		u_nt.frame(1'b1, 1'b0);
		expect_pat(lsc_pkg::PAT_INFO4);
		msk(1'b1);
		u_nt.bits(63, 1'b1);
		expect_pat(lsc_pkg::PAT_INFO4);
		u_nt.bits(1, 1'b1);
		expect_pat(lsc_pkg::PAT_INFO0);
		clr();
		$display("line pattern test done");
		for (int i = 0; i < 12; i++) begin
			k = $urandom_range(3, 0);
			if (k == 0) u_nt.frame(1'b0, 1'b0);
			if (k == 0) u_nt.bits(64, 1'b1);
			if (k == 1 || k == 2) u_nt.bits(1, 1'b0);
			if (k == 1) u_nt.frame(1'b0, 1'b1);
			if (k == 2) u_nt.frame(1'b1, 1'($urandom));
			if (k == 3) u_nt.bits(96, 1'b0);
			expect_pat(k[1:0]);
			if ($urandom_range(1, 0) == 1) clr();
		end
		$display("random line test done");
		report_and_stop();
	end
endmodule : test_line_status_and_clock_config
